// *** src/secc_pkg.sv ***
// Shared constants and types for the serial absolute encoder checker
package secc_pkg;

	// Clock period of the drive clock in nanoseconds
	localparam int CLK_NS = 8;

	// Serial clock periods in nanoseconds, one per rate code
	localparam int RATE_100K_NS = 10000;
	localparam int RATE_500K_NS = 2000;
	localparam int RATE_1M_NS = 1000;
	localparam int RATE_2M_NS = 500;

	// Half periods in drive clocks, rounded up so the rate never exceeds the nominal one
	localparam logic [9:0] HALF_100K = 10'((RATE_100K_NS / 2 + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] HALF_500K = 10'((RATE_500K_NS / 2 + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] HALF_1M = 10'((RATE_1M_NS / 2 + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] HALF_2M = 10'((RATE_2M_NS / 2 + CLK_NS - 1) / CLK_NS);

	// Rate codes held in the two top bits of the transfer rate setting
	localparam logic [1:0] RATE_CODE_100K = 2'h0;
	localparam logic [1:0] RATE_CODE_500K = 2'h1;
	localparam logic [1:0] RATE_CODE_1M = 2'h2;
	localparam int RATE_CODE_LSB = 14;

	// Register byte offsets
	localparam logic [7:0] OFS_FRAME_LEN = 8'h00;
	localparam logic [7:0] OFS_MT_REVS = 8'h04;
	localparam logic [7:0] OFS_ST_INCR = 8'h08;
	localparam logic [7:0] OFS_FMT_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_RATE = 8'h10;
	localparam logic [7:0] OFS_CTRL = 8'h14;
	localparam logic [7:0] OFS_CYCLE = 8'h18;
	localparam logic [7:0] OFS_ALARMS = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	localparam logic [7:0] OFS_POSITION = 8'h28;

	// Field positions
	localparam int FMT_PARITY_BIT = 12;
	localparam int FMT_ALARM_BIT = 14;
	localparam int CTRL_ARM_BIT = 0;
	localparam int CTRL_LINEAR_BIT = 1;
	localparam int CTRL_INCR_BIT = 2;
	localparam int ALARMS_READY_BIT = 8;

	// Alarm and event bit positions, shared by alarm and interrupt registers
	localparam int AL_RESOL = 0;
	localparam int AL_FRAME = 1;
	localparam int AL_MULTI = 2;
	localparam int AL_INCR = 3;
	localparam int AL_TMO = 4;
	localparam int EV_DONE = 5;
	localparam int AL_W = 5;
	localparam int EV_W = 6;

	// Displayed alarm numbers, decimal value carried in binary
	localparam logic [19:0] ALNUM_RESOL = 20'h4C19E;
	localparam logic [19:0] ALNUM_FRAME = 20'h4C19F;
	localparam logic [19:0] ALNUM_MULTI = 20'h4C1A0;
	localparam logic [19:0] ALNUM_INCR = 20'h4C1A4;
	localparam logic [19:0] ALNUM_TMO = 20'h4C1A5;

	// Reset values
	localparam logic [5:0] FRAME_LEN_RST = 6'h00;
	localparam logic [31:0] CYCLE_RST = 32'h0001E848;
	localparam logic [15:0] RATE_RST = 16'h0000;

	// Serial master sequencer states
	typedef enum logic [1:0] {
		SECC_IDLE,
		SECC_CLK_LO,
		SECC_CLK_HI
	} secc_state_t;

endpackage

// *** src/secc_sync.sv ***
`timescale 1ns/10ps
// Two-stage synchroniser for levels arriving from outside the clock domain
module secc_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic d_in,
	output logic q_out
);

	logic meta_r; // First stage, read only by the second stage
	logic sync_r; // Second stage, safe to use

	// Both stages clear to zero on reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= d_in;
			sync_r <= meta_r;
		end
	end

	assign q_out = sync_r;

endmodule // secc_sync

// *** src/secc_top.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// [R1] Frame length must equal all counted bits; linear mode only checks that it exceeds parity plus alarm bits
// [R2] Format bit 12 adds a parity bit
// [R3] Format bit 14 adds an alarm bit
// [R4] Linear encoder needs zero multi-turn setting
// [R5] No incremental signals raises alarm 311716
// [R6] Transfer unfinished at cycle end: time-out
// [R7] Rate bits 15:14 pick four clock rates
// [R8] Any alarm drops ready, stops, blocks starts
// [R9] Alarms stay latched until power cycle
// [R10] Zero single-turn resolution is an error
// [R11] Rate codes ascend from 100 kHz
// [R12] One clock per bit, MSB first
module secc_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	input wire logic ssi_data_in,
	output logic ssi_clk_out,
	output logic irq,
	output logic mode_group_ready,
	output logic channel_ready,
	output logic motion_stop,
	output logic start_block,
	output logic [19:0] alarm_display,
	output logic [4:0] alarm_flags,
	output logic position_valid
);

	// Bits needed to count v distinct values; zero for zero or one
	function automatic logic [5:0] bits_needed(input logic [31:0] v);
		logic [5:0] n;
		logic [31:0] top;
		n = 6'h00;
		top = v - 32'h00000001;
		if (v != 32'h00000000) begin
			for (int i = 0; i < 32; i++) begin
				if ((top >> i) != 32'h00000000) begin
					n = 6'(i + 1);
				end
			end
		end
		return n;
	endfunction

	// Software settings
	logic [5:0] frame_length_setting_r; // Total frame bits
	logic [31:0] multiturn_revolutions_setting_r; // Resolvable revolutions
	logic [31:0] singleturn_increments_setting_r; // Increments per revolution or nm
	logic [15:0] encoder_format_flags_r; // Parity and alarm bit presence
	logic [15:0] transfer_rate_setting_r; // Rate code in the top bits
	logic [2:0] ctrl_r; // Arm, linear, incremental signals present
	logic [31:0] cycle_len_r; // Position controller cycle in drive clocks

	// Latched alarms, interrupt state and read data
	logic [secc_pkg::AL_W-1:0] alarm_r; // Latched alarms
	logic [secc_pkg::EV_W-1:0] irq_stat_r; // Sticky event bits
	logic [secc_pkg::EV_W-1:0] irq_mask_r; // Event enables
	logic [31:0] rdata_r;
	logic irq_r;

	// Motion and display outputs
	logic ready_r;
	logic stop_r;
	logic [19:0] display_r;

	// Serial master state
	secc_pkg::secc_state_t state_r; // Sequencer state
	logic [9:0] half_cnt_r; // Drive clocks left in this half period
	logic [5:0] bits_left_r; // Bits still to be clocked
	logic [31:0] shift_r; // Incoming frame, low bits kept
	logic [31:0] position_r; // Last completed frame
	logic sclk_r; // Serial clock, idles high
	logic done_r; // One-cycle pulse when a frame completes
	logic [31:0] cyc_cnt_r; // Position controller cycle timer

	// Synchronised serial data from the encoder
	logic ssi_data_s;

	secc_sync u_data_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d_in(ssi_data_in),
		.q_out(ssi_data_s)
	);

	// Register decode
	wire wr_frame = reg_we && (reg_addr == secc_pkg::OFS_FRAME_LEN);
	wire wr_mt = reg_we && (reg_addr == secc_pkg::OFS_MT_REVS);
	wire wr_st = reg_we && (reg_addr == secc_pkg::OFS_ST_INCR);
	wire wr_fmt = reg_we && (reg_addr == secc_pkg::OFS_FMT_FLAGS);
	wire wr_rate = reg_we && (reg_addr == secc_pkg::OFS_RATE);
	wire wr_ctrl = reg_we && (reg_addr == secc_pkg::OFS_CTRL);
	wire wr_cycle = reg_we && (reg_addr == secc_pkg::OFS_CYCLE);
	wire wr_istat = reg_we && (reg_addr == secc_pkg::OFS_IRQ_STAT);
	wire wr_imask = reg_we && (reg_addr == secc_pkg::OFS_IRQ_MASK);

	// Configuration flags
	wire armed = ctrl_r[secc_pkg::CTRL_ARM_BIT];
	wire linear = ctrl_r[secc_pkg::CTRL_LINEAR_BIT];
	wire incr_present = ctrl_r[secc_pkg::CTRL_INCR_BIT];
	wire parity_on = encoder_format_flags_r[secc_pkg::FMT_PARITY_BIT]; // [R2]
	wire alarm_bit_on = encoder_format_flags_r[secc_pkg::FMT_ALARM_BIT]; // [R3]

	// Expected frame length; a linear scale carries no multi-turn bits
	wire [5:0] mt_bits = linear ? 6'h00 : bits_needed(multiturn_revolutions_setting_r);
	wire [5:0] st_bits = bits_needed(singleturn_increments_setting_r);
	wire [7:0] extra_bits = {7'h00, parity_on} + {7'h00, alarm_bit_on}; // [R2] [R3]
	wire [7:0] exp_len = {2'h0, mt_bits} + {2'h0, st_bits} + extra_bits; // [R1]
	// Linear resolution is in nm, so only a non-empty position field is required
	wire len_bad = linear ? ({2'h0, frame_length_setting_r} <= extra_bits)
		: ({2'h0, frame_length_setting_r} != exp_len); // [R1]

	// Configuration checks, only judged once software arms the block
	wire [secc_pkg::AL_W-1:0] check_fail;
	assign check_fail[secc_pkg::AL_RESOL] = singleturn_increments_setting_r == 32'h0; // [R10]
	assign check_fail[secc_pkg::AL_FRAME] = len_bad; // [R1]
	assign check_fail[secc_pkg::AL_MULTI] = linear
		&& (multiturn_revolutions_setting_r != 32'h0); // [R4]
	assign check_fail[secc_pkg::AL_INCR] = !incr_present; // [R5]
	assign check_fail[secc_pkg::AL_TMO] = 1'b0;

	// Cycle boundary and time-out detection
	wire cycle_tick = armed && (cyc_cnt_r >= cycle_len_r - 32'h1);
	wire busy = state_r != secc_pkg::SECC_IDLE;
	wire timeout = cycle_tick && busy; // [R6]

	// New alarm bits this cycle
	wire [secc_pkg::AL_W-1:0] tmo_set = {{(secc_pkg::AL_W-1){1'b0}}, timeout} << secc_pkg::AL_TMO;
	wire [secc_pkg::AL_W-1:0] alarm_set = (armed ? check_fail : '0) | tmo_set; // [R6]
	wire [secc_pkg::AL_W-1:0] alarm_nxt = alarm_r | alarm_set; // [R9]
	wire any_alarm = |alarm_nxt;

	// Frames start only while armed and healthy
	wire start_frame = cycle_tick && !busy && !any_alarm
		&& (frame_length_setting_r != 6'h00);

	// Rate selection, ascending codes
	wire [1:0] rate_code = transfer_rate_setting_r[secc_pkg::RATE_CODE_LSB +: 2]; // [R7]
	wire [9:0] half_len = (rate_code == secc_pkg::RATE_CODE_100K) ? secc_pkg::HALF_100K
		: (rate_code == secc_pkg::RATE_CODE_500K) ? secc_pkg::HALF_500K
		: (rate_code == secc_pkg::RATE_CODE_1M) ? secc_pkg::HALF_1M
		: secc_pkg::HALF_2M; // [R7] [R11]
	wire half_end = half_cnt_r == 10'h001;

	// Interrupt events: every new alarm plus completed frames
	wire [secc_pkg::EV_W-1:0] ev_wdata = reg_wdata[secc_pkg::EV_W-1:0]; // Event field of a write
	wire [secc_pkg::EV_W-1:0] events = {done_r, alarm_set & ~alarm_r};
	wire [secc_pkg::EV_W-1:0] irq_stat_nxt = (irq_stat_r & ~(wr_istat ? ev_wdata : '0))
		| events;

	// Display picks the lowest numbered pending alarm
	wire [19:0] display_nxt = alarm_nxt[secc_pkg::AL_RESOL] ? secc_pkg::ALNUM_RESOL
		: alarm_nxt[secc_pkg::AL_FRAME] ? secc_pkg::ALNUM_FRAME
		: alarm_nxt[secc_pkg::AL_MULTI] ? secc_pkg::ALNUM_MULTI
		: alarm_nxt[secc_pkg::AL_INCR] ? secc_pkg::ALNUM_INCR
		: alarm_nxt[secc_pkg::AL_TMO] ? secc_pkg::ALNUM_TMO
		: 20'h00000; // [R8]

	// Read multiplexer; unmapped offsets read as zero
	wire [31:0] rd_mux = (reg_addr == secc_pkg::OFS_FRAME_LEN) ? {26'h0, frame_length_setting_r}
		: (reg_addr == secc_pkg::OFS_MT_REVS) ? multiturn_revolutions_setting_r
		: (reg_addr == secc_pkg::OFS_ST_INCR) ? singleturn_increments_setting_r
		: (reg_addr == secc_pkg::OFS_FMT_FLAGS) ? {16'h0, encoder_format_flags_r}
		: (reg_addr == secc_pkg::OFS_RATE) ? {16'h0, transfer_rate_setting_r}
		: (reg_addr == secc_pkg::OFS_CTRL) ? {29'h0, ctrl_r}
		: (reg_addr == secc_pkg::OFS_CYCLE) ? cycle_len_r
		: (reg_addr == secc_pkg::OFS_ALARMS) ? {23'h0, ready_r, 3'h0, alarm_r}
		: (reg_addr == secc_pkg::OFS_IRQ_STAT) ? {26'h0, irq_stat_r}
		: (reg_addr == secc_pkg::OFS_IRQ_MASK) ? {26'h0, irq_mask_r}
		: (reg_addr == secc_pkg::OFS_POSITION) ? position_r
		: 32'h00000000;

	// Settings written by software
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frame_length_setting_r <= secc_pkg::FRAME_LEN_RST;
			multiturn_revolutions_setting_r <= 32'h00000000;
			singleturn_increments_setting_r <= 32'h00000000;
			encoder_format_flags_r <= 16'h0000;
			transfer_rate_setting_r <= secc_pkg::RATE_RST;
			ctrl_r <= 3'h0;
			cycle_len_r <= secc_pkg::CYCLE_RST;
		end else begin
			if (wr_frame) begin
				frame_length_setting_r <= reg_wdata[5:0];
			end
			if (wr_mt) begin
				multiturn_revolutions_setting_r <= reg_wdata;
			end
			if (wr_st) begin
				singleturn_increments_setting_r <= reg_wdata;
			end
			if (wr_fmt) begin
				encoder_format_flags_r <= reg_wdata[15:0];
			end
			if (wr_rate) begin
				transfer_rate_setting_r <= reg_wdata[15:0];
			end
			if (wr_ctrl) begin
				ctrl_r <= reg_wdata[2:0];
			end
			if (wr_cycle) begin
				cycle_len_r <= reg_wdata;
			end
		end
	end

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_r <= 32'h00000000;
		end else begin
			rdata_r <= reg_re ? rd_mux : 32'h00000000;
		end
	end

	// Alarm latches; only the power-on reset clears them
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			alarm_r <= '0;
		end else begin
			alarm_r <= alarm_nxt; // [R9]
		end
	end

	// Interrupt status and mask; a set in the clear cycle wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			irq_r <= 1'b0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			if (wr_imask) begin
				irq_mask_r <= ev_wdata;
			end
			irq_r <= |(irq_stat_nxt & (wr_imask ? ev_wdata : irq_mask_r));
		end
	end

	// Drive status outputs; ready needs arming and a clean alarm set
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ready_r <= 1'b0;
			stop_r <= 1'b0;
			display_r <= 20'h00000;
		end else begin
			ready_r <= armed && !any_alarm; // [R8]
			stop_r <= any_alarm; // [R8]
			display_r <= display_nxt; // [R8]
		end
	end

	// Position controller cycle timer, free running while armed
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cyc_cnt_r <= 32'h00000000;
		end else if (!armed || cycle_tick) begin
			cyc_cnt_r <= 32'h00000000;
		end else begin
			cyc_cnt_r <= cyc_cnt_r + 32'h00000001;
		end
	end

	// Serial master: one low and one high half per bit, sampled at the end of high
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= secc_pkg::SECC_IDLE;
			half_cnt_r <= 10'h000;
			bits_left_r <= 6'h00;
			shift_r <= 32'h00000000;
			position_r <= 32'h00000000;
			sclk_r <= 1'b1;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
				secc_pkg::SECC_IDLE: begin
					// Clock idles high so the encoder holds its frame
					sclk_r <= 1'b1;
					if (start_frame) begin
						state_r <= secc_pkg::SECC_CLK_LO;
						sclk_r <= 1'b0;
						half_cnt_r <= half_len;
						bits_left_r <= frame_length_setting_r;
						shift_r <= 32'h00000000;
					end
				end
				secc_pkg::SECC_CLK_LO: begin
					if (timeout) begin
						// Abort: leave the link idle, the alarm stops further frames
						state_r <= secc_pkg::SECC_IDLE;
						sclk_r <= 1'b1;
					end else if (half_end) begin
						state_r <= secc_pkg::SECC_CLK_HI;
						sclk_r <= 1'b1; // [R12]
						half_cnt_r <= half_len;
					end else begin
						half_cnt_r <= half_cnt_r - 10'h001;
					end
				end
				secc_pkg::SECC_CLK_HI: begin
					if (timeout) begin
						state_r <= secc_pkg::SECC_IDLE;
					end else if (half_end) begin
						// First bit in is the MSB, it ends highest
						shift_r <= {shift_r[30:0], ssi_data_s}; // [R12]
						bits_left_r <= bits_left_r - 6'h01;
						if (bits_left_r == 6'h01) begin
							state_r <= secc_pkg::SECC_IDLE;
							position_r <= {shift_r[30:0], ssi_data_s};
							done_r <= 1'b1;
						end else begin
							state_r <= secc_pkg::SECC_CLK_LO;
							sclk_r <= 1'b0;
							half_cnt_r <= half_len;
						end
					end else begin
						half_cnt_r <= half_cnt_r - 10'h001;
					end
				end
				default: begin
					state_r <= secc_pkg::SECC_IDLE;
					sclk_r <= 1'b1;
				end
			endcase
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = rdata_r;
	assign ssi_clk_out = sclk_r;
	assign irq = irq_r;
	assign mode_group_ready = ready_r;
	assign channel_ready = ready_r;
	assign motion_stop = stop_r;
	assign start_block = stop_r;
	assign alarm_display = display_r;
	assign alarm_flags = alarm_r;
	assign position_valid = done_r;

endmodule // secc_top

// *** dv/secc_props.sv ***
`timescale 1ns/10ps
// Port-level checks for the serial encoder checker
module secc_props (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [31:0] reg_rdata,
	input wire logic ssi_data_in,
	input wire logic ssi_clk_out,
	input wire logic irq,
	input wire logic mode_group_ready,
	input wire logic channel_ready,
	input wire logic motion_stop,
	input wire logic start_block,
	input wire logic [19:0] alarm_display,
	input wire logic [4:0] alarm_flags,
	input wire logic position_valid
);
	logic [1:0] rate_r; // Rate code last written
	logic [5:0] flen_r; // Frame length last written
	logic [9:0] lo_cnt_r; // Cycles the serial clock has stayed low
	logic [6:0] fall_cnt_r; // Clock pulses since the last frame end
	logic [9:0] half; // Expected half period for the rate code
	assign half = rate_r == 2'h0 ? secc_pkg::HALF_100K : rate_r == 2'h1 ? secc_pkg::HALF_500K :
		rate_r == 2'h2 ? secc_pkg::HALF_1M : secc_pkg::HALF_2M;
	// Shadow settings; only valid while software leaves them alone during frames
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rate_r <= 2'h0;
			flen_r <= 6'h00;
		end else if (reg_we && reg_addr == 8'h10) begin
			rate_r <= reg_wdata[15:14];
		end else if (reg_we && reg_addr == 8'h00) begin
			flen_r <= reg_wdata[5:0];
		end
	end
	// Low span and pulse count of the serial clock
	always_ff @(posedge clk) begin
		lo_cnt_r <= ssi_clk_out ? 10'h000 : lo_cnt_r + 10'h001;
		if (sys_rst || position_valid) begin
			fall_cnt_r <= 7'h00;
		end else if ($fell(ssi_clk_out)) begin
			fall_cnt_r <= fall_cnt_r + 7'h01;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	a_ready_pair: assert property (mode_group_ready == channel_ready
		&& motion_stop == start_block && (!mode_group_ready || alarm_display == 20'h00000))
		else $error("ready or stop pair disagrees");
	a_stop_on_alarm: assert property ((motion_stop == (alarm_flags != 5'h00)) &&
		!(mode_group_ready && motion_stop)) else $error("stop or ready wrong for alarms");
	a_alarm_latched: assert property ((alarm_flags != 5'h00) |=>
		((alarm_flags & $past(alarm_flags)) == $past(alarm_flags))) else $error("alarm dropped");
	a_display_resol: assert property (alarm_flags[0] |->
		alarm_display == secc_pkg::ALNUM_RESOL) else $error("resolution alarm number wrong");
	a_display_incr: assert property (alarm_flags == 5'h08 |->
		alarm_display == secc_pkg::ALNUM_INCR) else $error("incremental alarm number wrong");
	a_clk_low_span: assert property ($rose(ssi_clk_out) |-> lo_cnt_r == half)
		else $error("serial clock low half wrong");
	a_frame_bits: assert property (position_valid |-> fall_cnt_r == {1'b0, flen_r})
		else $error("pulse count differs from frame length");
	a_valid_pulse: assert property (position_valid |-> ssi_clk_out ##1 !position_valid)
		else $error("frame end pulse malformed");
	a_tmo_idle: assert property (alarm_flags[4] |=> ssi_clk_out [*4])
		else $error("serial clock runs after time-out");
endmodule // secc_props
bind secc_top secc_props secc_props_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
	.ssi_data_in(ssi_data_in), .ssi_clk_out(ssi_clk_out), .irq(irq),
	.mode_group_ready(mode_group_ready), .channel_ready(channel_ready),
	.motion_stop(motion_stop), .start_block(start_block), .alarm_display(alarm_display),
	.alarm_flags(alarm_flags), .position_valid(position_valid));

// *** dv/secc_enc_model.sv ***
`timescale 1ns/10ps
// Behavioural absolute encoder on the serial link
module secc_enc_model #(
	parameter int MONO_NS = 6000
) (
	input wire logic ssi_clk,
	input wire logic slow,
	input wire logic [5:0] frame_len,
	input wire logic [31:0] word,
	output logic ssi_data
);
	int bit_idx; // Bits still to send
	bit busy; // Frame in progress
	initial begin
		ssi_data = 1'b1;
		bit_idx = 0;
		busy = 1'b0;
	end
	// First falling edge freezes the frame
	always @(negedge ssi_clk) begin
		if (!busy) begin
			busy = 1'b1;
			bit_idx = frame_len;
		end
	end
	// Each rising edge puts out the next bit, highest first; late edges when slow
	always @(posedge ssi_clk) begin
		if (busy && bit_idx > 0) begin
			bit_idx = bit_idx - 1;
			ssi_data <= #(slow ? 150 : 5) word[bit_idx];
			if (bit_idx == 0) begin
				// Line idles high once the hold time has run out
				#(MONO_NS);
				busy = 1'b0;
				ssi_data = 1'b1;
			end
		end
	end
endmodule // secc_enc_model

// *** dv/secc_top_tb.sv ***
`timescale 1ns/10ps
// Self-checking bench for the serial encoder checker
module secc_top_tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic [31:0] reg_rdata;
	logic ssi_data_in, ssi_clk_out, irq, mode_group_ready, channel_ready, motion_stop, start_block;
	logic [19:0] alarm_display;
	logic [4:0] alarm_flags;
	logic position_valid;
	logic slow = 1'b0; // Late encoder data edges
	logic [5:0] n = 6'h00; // Frame length the encoder sends
	logic [31:0] w = 32'h0; // Word the encoder sends
	int fails = 0;
	int cmp_count = 0;
	int seed = 16;
	// Alarm table: frame, linear multi-turn, no incremental, zero resolution, good
	logic [5:0] flens [5] = '{6'h1A, 6'h14, 6'h04, 6'h02, 6'h19};
	logic [31:0] revs [5] = '{32'h1000, 32'h8, 32'h4, 32'h4, 32'h1000};
	logic [31:0] sts [5] = '{32'h1000, 32'h5, 32'h4, 32'h0, 32'h1000};
	logic [31:0] fmts [5] = '{32'h4000, 32'h0, 32'h0, 32'h0, 32'h4000};
	logic [31:0] ctls [5] = '{32'h5, 32'h7, 32'h1, 32'h5, 32'h5};
	logic [4:0] exps [5] = '{5'h02, 5'h04, 5'h08, 5'h01, 5'h00};
	logic [19:0] disps [5] = '{secc_pkg::ALNUM_FRAME, secc_pkg::ALNUM_MULTI,
		secc_pkg::ALNUM_INCR, secc_pkg::ALNUM_RESOL, 20'h00000};
	always #4 clk = ~clk;
	secc_top secc_top_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .ssi_data_in(ssi_data_in),
		.ssi_clk_out(ssi_clk_out), .irq(irq), .mode_group_ready(mode_group_ready),
		.channel_ready(channel_ready), .motion_stop(motion_stop), .start_block(start_block),
		.alarm_display(alarm_display), .alarm_flags(alarm_flags), .position_valid(position_valid));
	secc_enc_model secc_enc_model_i (.ssi_clk(ssi_clk_out), .slow(slow), .frame_len(n), .word(w),
		.ssi_data(ssi_data_in));
	// Compare one result word
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
	// Expected frame length of a rotary encoder
	function automatic logic [5:0] frame_bits(input int mt, input int st, input logic [31:0] f);
		return 6'($clog2(mt) + $clog2(st) + f[12] + f[14]);
	endfunction
	// Power cycle, then program and arm; control word goes last
	task automatic cfg(input logic [5:0] fl, input logic [31:0] mt, st, fm, rt, cyc, ctl);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		wr(8'h00, {26'h0, fl});
		wr(8'h04, mt);
		wr(8'h08, st);
		wr(8'h0C, fm);
		wr(8'h10, rt);
		wr(8'h18, cyc);
		wr(8'h14, ctl);
	endtask
	// Alarm outputs, interrupt mask and clear, latch past disarm
	task automatic check_alarm(input logic [4:0] e, input logic [19:0] d);
		logic [31:0] r;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(32'(alarm_flags), 32'(e));
		chk(32'(alarm_display), 32'(d));
		chk(32'({mode_group_ready, channel_ready, motion_stop, start_block}), e != 0 ? 3 : 12);
		wr(8'h24, 32'(e));
		@(negedge clk);
		chk(32'(irq), 32'(e != 0));
		wr(8'h14, 32'h0);
		wr(8'h20, 32'h3F);
		rd(8'h1C, r);
		chk(r, 32'(e));
		chk(32'(irq), 32'h0);
	endtask
	// Expected run is near 66000 cycles; give up at about 95000
	initial begin
		#760000;
		fails++;
		complete_run;
	end
	initial begin
		logic [31:0] r, fl;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h3C, r);
		chk(r, 32'h0);
		rd(8'h18, r);
		chk(r, secc_pkg::CYCLE_RST);
		// Good frames at every rate code, random flags, content and unused rate bits
		for (int k = 0; k < 4; k++) begin
			fl = $random(seed) & 32'h5000;
			w <= $random(seed);
			slow <= k[0];
			n <= frame_bits(4, 4, fl);
			cfg(frame_bits(4, 4, fl), 4, 4, fl, {16'h0, k[1:0], 14'($random(seed))}, 12000, 5);
			for (int i = 0; i < 30000 && position_valid !== 1'b1; i++) @(negedge clk);
			chk(32'(position_valid), 32'h1);
			rd(8'h28, r);
			chk(r, w & ((32'h1 << n) - 1));
			chk(32'(alarm_flags), 32'h0);
			rd(8'h20, r);
			chk(r, 32'h1 << secc_pkg::EV_DONE);
			$display("rate code %0d done", k);
		end
		for (int k = 0; k < 5; k++) begin
			cfg(flens[k], revs[k], sts[k], fmts[k], 32'hC000, 60000, ctls[k]);
			check_alarm(exps[k], disps[k]);
			$display("alarm case %0d done", k);
		end
		// Slowest rate with a long frame cannot fit the controller cycle
		n <= 6'h18;
		cfg(6'h18, 32'h1000, 32'h1000, 32'h0, 32'h0, 3500, 5);
		repeat (7200) @(posedge clk);
		@(negedge clk);
		chk(32'(alarm_flags), 32'h10);
		chk(32'(alarm_display), 32'(secc_pkg::ALNUM_TMO));
		chk(32'(ssi_clk_out), 32'h1);
		$display("time-out case done");
		complete_run;
	end
endmodule // secc_top_tb
